// File: rtl/lbt_layer_blend.sv
// Layer compositing controls: APB registers and one-stage pixel compositor
//
// Contract
// - Control bit 2 enables overlay window two transparency.
// - Control bit 1 enables overlay window one transparency.
// - Window two transparency reveals only windows beneath, never background.
// - Window one transparency reveals only windows beneath, never background.
// - Control bit 0 is reserved and reads zero.
// - Ratio bits 15-12 act for key four only while its enable is set.
// - Ratio bits 11-8 act for key three only while its enable is set.
// - Ratio bits 7-4 act for key two only while its enable is set.
// - Ratio bits 3-0 act for key one only while its enable is set.
// - Ratio code n weighs the upper pixel at n times 12.5 percent.
// - Window one key colour is a 5-6-5 register, red on top.
//
// The APB interface to the registers is this design's own decision.
`timescale 1ns/1ps
`default_nettype none

module lbt_layer_blend
  import lbt_pkg::*;
(
  input wire logic clk_in,
  input wire logic reset_in,
  // APB slave
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic [3:0] pstrb_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  // Pixel path, bottom to top: main, overlay one, overlay two
  input wire logic pix_valid_in,
  input wire logic main_present_in,
  input wire logic [15:0] main_pix_in,
  input wire logic overlay_window_one_present_in,
  input wire logic [15:0] overlay_window_one_pix_in,
  input wire logic overlay_window_two_present_in,
  input wire logic [15:0] overlay_window_two_pix_in,
  output logic pix_valid_out,
  output logic [15:0] pix_out
);

  lbt_state_s s_q;
  lbt_state_s s_d;

  // ==========================================================
  // Address decode
  logic word_ok;
  logic [9:0] idx;
  logic [9:0] bkey_off;
  logic hit_ctrl;
  logic hit_bg;
  logic hit_ratio;
  logic hit_tkey1;
  logic hit_tkey2;
  logic hit_status;
  logic [NUM_BKEY-1:0] hit_bkey;
  logic mapped;
  logic [15:0] rd_word;
  logic [15:0] wmask;

  assign idx = paddr_in[11:2];
  assign word_ok = (paddr_in[1:0] == 2'h0);
  assign bkey_off = idx - IDX_BKEY1;

  always_comb begin
    hit_ctrl = 1'b0;
    hit_bg = 1'b0;
    hit_ratio = 1'b0;
    hit_tkey1 = 1'b0;
    hit_tkey2 = 1'b0;
    hit_status = 1'b0;
    hit_bkey = '0;
    if (!word_ok) begin
      hit_ctrl = 1'b0;
    end else if (idx == IDX_CTRL) begin
      hit_ctrl = 1'b1;
    end else if (idx == IDX_BG) begin
      hit_bg = 1'b1;
    end else if (idx == IDX_RATIO) begin
      hit_ratio = 1'b1;
    end else if (idx == IDX_TKEY1) begin
      hit_tkey1 = 1'b1;
    end else if (idx == IDX_TKEY2) begin
      hit_tkey2 = 1'b1;
    end else if (idx == IDX_STATUS) begin
      hit_status = 1'b1;
    end else if ((idx >= IDX_BKEY1) && (idx < IDX_BKEY1 + 10'(NUM_BKEY))) begin
      hit_bkey[bkey_off[1:0]] = 1'b1;
    end
    mapped = hit_ctrl | hit_bg | hit_ratio | hit_tkey1 | hit_tkey2 | hit_status | (|hit_bkey);
  end

  // Read multiplexer; reserved and unused bits other than control bit 7 read zero
  always_comb begin
    rd_word = 16'h0000;
    if (hit_ctrl) begin
      rd_word = s_q.ctrl & CTRL_WMASK;
    end else if (hit_bg) begin
      rd_word = s_q.bg;
    end else if (hit_ratio) begin
      rd_word = s_q.ratio;
    end else if (hit_tkey1) begin
      rd_word = s_q.tkey[0];
    end else if (hit_tkey2) begin
      rd_word = s_q.tkey[1];
    end else if (hit_status) begin
      rd_word = {9'h000, s_q.status};
    end else begin
      for (int k = 0; k < NUM_BKEY; k++) begin
        if (hit_bkey[k]) begin
          rd_word = s_q.bkey[k];
        end
      end
    end
  end

  // ==========================================================
  // Bus phases and write merge
  logic apb_setup;
  logic apb_access;
  logic apb_write;
  logic [15:0] wr_bits;
  logic [15:0] keep_bits;

  // Setup edge latches read data; access edge commits writes
  assign apb_setup = psel_in & ~penable_in;
  assign apb_access = psel_in & penable_in;
  assign apb_write = apb_access & pwrite_in;

  // Byte lanes above 15 carry nothing
  assign wmask = {{8{pstrb_in[1]}}, {8{pstrb_in[0]}}};
  assign wr_bits = pwdata_in[15:0] & wmask;
  assign keep_bits = ~wmask;

  // Read data is latched in setup, so access always completes in one cycle
  assign pready_out = apb_access;
  assign pslverr_out = apb_access & ~mapped;
  assign prdata_out = s_q.prdata;

  // ==========================================================
  // Compositing: transparency resolution
  lbt_layer_if main_l ();
  lbt_layer_if ow1_l ();
  lbt_layer_if ow2_l ();
  lbt_layer_if under2_l ();
  lbt_layer_if top_l ();
  logic tr1_hit;
  logic tr2_hit;

  assign main_l.present = main_present_in;
  assign main_l.colour = main_pix_in;
  assign ow1_l.present = overlay_window_one_present_in;
  assign ow1_l.colour = overlay_window_one_pix_in;
  assign ow2_l.present = overlay_window_two_present_in;
  assign ow2_l.colour = overlay_window_two_pix_in;

  lbt_key_resolve u_res_ow1 (
    .upper(ow1_l),
    .lower(main_l),
    .key_in(s_q.tkey[0]),
    .enable_in(s_q.ctrl[CTRL_OW1_TR_BIT]),
    .result(under2_l),
    .hit_out(tr1_hit)
  );

  lbt_key_resolve u_res_ow2 (
    .upper(ow2_l),
    .lower(under2_l),
    .key_in(s_q.tkey[1]),
    .enable_in(s_q.ctrl[CTRL_OW2_TR_BIT]),
    .result(top_l),
    .hit_out(tr2_hit)
  );

  // ==========================================================
  // Compositing: per blend key
  logic [NUM_BKEY-1:0] key_en;
  logic [NUM_BKEY-1:0] key_match;
  logic [NUM_BKEY-1:0] bk_hit;
  logic [NUM_BKEY-1:0][3:0] key_ratio;

  // One copy per key; the enable gates both the match and the ratio
  for (genvar g = 0; g < NUM_BKEY; g++) begin : g_bkey
    assign key_en[g] = s_q.ctrl[CTRL_BKEY_EN_LSB + g];
    assign key_match[g] = (top_l.colour == s_q.bkey[g]);
    assign bk_hit[g] = key_en[g] & key_match[g];
    assign key_ratio[g] = s_q.ratio[g*RATIO_W +: RATIO_W];
  end

  // ==========================================================
  // Compositing: blend against the layer beneath the shown pixel
  logic ow2_shown;
  logic ow1_shown;
  logic [15:0] below;
  logic [3:0] sel_ratio;
  logic [15:0] mixed;
  logic blend_on;

  // Shown layer decides what the blend mixes with
  assign ow2_shown = ow2_l.present & ~tr2_hit;
  assign ow1_shown = ~ow2_shown & under2_l.present & ow1_l.present & ~tr1_hit;

  always_comb begin
    // Layer beneath the topmost shown window; background if none
    if (ow2_shown) begin
      below = under2_l.present ? under2_l.colour : s_q.bg;
    end else if (ow1_shown) begin
      below = main_l.present ? main_l.colour : s_q.bg;
    end else begin
      below = s_q.bg;
    end
    // Lowest numbered key wins when several match
    sel_ratio = RATIO_FULL;
    for (int k = NUM_BKEY - 1; k >= 0; k--) begin
      if (bk_hit[k]) begin
        sel_ratio = key_ratio[k];
      end
    end
    blend_on = top_l.present & (|bk_hit);
  end

  lbt_blend_mix u_mix (
    .upper_in(top_l.colour),
    .lower_in(below),
    .ratio_in(sel_ratio),
    .mix_out(mixed)
  );

  // ==========================================================
  // Shown pixel and per-pixel status
  logic bg_shown;
  logic [15:0] pix_next;
  logic [6:0] status_next;

  always_comb begin
    bg_shown = ~top_l.present;
    if (blend_on) begin
      pix_next = mixed;
    end else if (!bg_shown) begin
      pix_next = top_l.colour;
    end else begin
      // Nothing covers the pixel
      pix_next = s_q.bg;
    end
    // Last valid pixel only, not sticky
    status_next = {bg_shown, bk_hit, tr2_hit, tr1_hit};
  end

  // ==========================================================
  // Next state
  always_comb begin
    s_d = s_q;
    if (apb_setup) begin
      s_d.prdata = {16'h0000, rd_word};
    end
    if (apb_write) begin
      if (hit_ctrl) begin
        s_d.ctrl = ((s_q.ctrl & keep_bits) | wr_bits) & CTRL_WMASK;
      end else if (hit_bg) begin
        s_d.bg = (s_q.bg & keep_bits) | wr_bits;
      end else if (hit_ratio) begin
        s_d.ratio = (s_q.ratio & keep_bits) | wr_bits;
      end else if (hit_tkey1) begin
        s_d.tkey[0] = (s_q.tkey[0] & keep_bits) | wr_bits;
      end else if (hit_tkey2) begin
        s_d.tkey[1] = (s_q.tkey[1] & keep_bits) | wr_bits;
      end else begin
        // Status and unmapped words take no write
        for (int k = 0; k < NUM_BKEY; k++) begin
          if (hit_bkey[k]) begin
            s_d.bkey[k] = (s_q.bkey[k] & keep_bits) | wr_bits;
          end
        end
      end
    end

    s_d.pix_valid = pix_valid_in;
    // Pixel and status hold between valid samples
    if (pix_valid_in) begin
      s_d.pix = pix_next;
      s_d.status = status_next;
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      // Registers take their defaults; read data, status and pixel clear
      s_q <= '0;
      s_q.ctrl <= CTRL_RST;
      s_q.bg <= BG_RST;
      s_q.ratio <= RATIO_RST;
      s_q.tkey <= {2{KEY_RST}};
      s_q.bkey <= {NUM_BKEY{KEY_RST}};
    end else begin
      s_q <= s_d;
    end
  end

  // ==========================================================
  // Outputs come straight from the state flops
  assign pix_valid_out = s_q.pix_valid;
  assign pix_out = s_q.pix;

endmodule : lbt_layer_blend

`default_nettype wire

// File: rtl/lbt_pkg.sv
// Package: register map, field layout and state type of the layer blend block
`default_nettype none

package lbt_pkg;

  // ==========================================================
  // Register indices (byte address = index * 4)
  localparam logic [9:0] IDX_CTRL = 10'h204;
  localparam logic [9:0] IDX_BG = 10'h206;
  localparam logic [9:0] IDX_RATIO = 10'h208;
  localparam logic [9:0] IDX_TKEY1 = 10'h20C;
  localparam logic [9:0] IDX_TKEY2 = 10'h20E;
  localparam logic [9:0] IDX_BKEY1 = 10'h210;
  localparam logic [9:0] IDX_STATUS = 10'h218;

  // ==========================================================
  // Field positions
  localparam int CTRL_OW1_TR_BIT = 1;
  localparam int CTRL_OW2_TR_BIT = 2;
  localparam int CTRL_BKEY_EN_LSB = 8;
  localparam logic [15:0] CTRL_WMASK = 16'h0F86;
  localparam int RED_LSB = 11;
  localparam int GREEN_LSB = 5;
  localparam int BLUE_LSB = 0;
  localparam int RATIO_W = 4;
  localparam int NUM_BKEY = 4;
  localparam logic [3:0] RATIO_FULL = 4'h8;

  // ==========================================================
  // Reset values
  localparam logic [15:0] CTRL_RST = 16'h0000;
  localparam logic [15:0] BG_RST = 16'h0000;
  localparam logic [15:0] RATIO_RST = 16'h8888;
  localparam logic [15:0] KEY_RST = 16'h0000;

  // ==========================================================
  // Whole state of the top module
  typedef struct packed {
    logic [15:0] ctrl;
    logic [15:0] bg;
    logic [15:0] ratio;
    logic [1:0][15:0] tkey;
    logic [NUM_BKEY-1:0][15:0] bkey;
    logic [6:0] status;
    logic [31:0] prdata;
    logic pix_valid;
    logic [15:0] pix;
  } lbt_state_s;

endpackage : lbt_pkg

`default_nettype wire

// File: rtl/lbt_layer_if.sv
// Interface: one RGB 5-6-5 layer sample with its coverage flag
`timescale 1ns/1ps
`default_nettype none

interface lbt_layer_if;
  logic present;
  logic [15:0] colour;
  modport src (output present, output colour);
  modport snk (input present, input colour);
endinterface : lbt_layer_if

`default_nettype wire

// File: rtl/lbt_key_resolve.sv
// Transparency resolution of one overlay window over the layers beneath it
`timescale 1ns/1ps
`default_nettype none

module lbt_key_resolve (
  lbt_layer_if.snk upper,
  lbt_layer_if.snk lower,
  input wire logic [15:0] key_in,
  input wire logic enable_in,
  lbt_layer_if.src result,
  output logic hit_out
);

  // ==========================================================
  // Key hit only counts when some window lies beneath
  always_comb begin
    hit_out = upper.present && enable_in && (upper.colour == key_in) && lower.present;
    if (!upper.present) begin
      result.present = lower.present;
      result.colour = lower.colour;
    end else if (hit_out) begin
      result.present = 1'b1;
      result.colour = lower.colour;
    end else begin
      // Background never shows through; key colour stays visible
      result.present = 1'b1;
      result.colour = upper.colour;
    end
  end

endmodule : lbt_key_resolve

`default_nettype wire

// File: rtl/lbt_blend_mix.sv
// Ratio-weighted mix of two RGB 5-6-5 pixels in eighths
`timescale 1ns/1ps
`default_nettype none

module lbt_blend_mix
  import lbt_pkg::*;
(
  input wire logic [15:0] upper_in,
  input wire logic [15:0] lower_in,
  input wire logic [3:0] ratio_in,
  output logic [15:0] mix_out
);

  logic [3:0] r;
  logic [3:0] inv;
  logic [9:0] sum_r;
  logic [9:0] sum_g;
  logic [9:0] sum_b;

  // ==========================================================
  // Per-component weighted sum
  always_comb begin
    // Reserved codes are clamped to full weight to keep the sum in range
    r = (ratio_in > RATIO_FULL) ? RATIO_FULL : ratio_in;
    inv = RATIO_FULL - r;
    sum_r = 10'(upper_in[RED_LSB +: 5]) * 10'(r) + 10'(lower_in[RED_LSB +: 5]) * 10'(inv);
    sum_g = 10'(upper_in[GREEN_LSB +: 6]) * 10'(r) + 10'(lower_in[GREEN_LSB +: 6]) * 10'(inv);
    sum_b = 10'(upper_in[BLUE_LSB +: 5]) * 10'(r) + 10'(lower_in[BLUE_LSB +: 5]) * 10'(inv);
    mix_out = {sum_r[7:3], sum_g[8:3], sum_b[7:3]};
  end

endmodule : lbt_blend_mix

`default_nettype wire

// File: testbench/lbt_layer_blend_properties.sv
// Checker: port-level properties of the layer blend block
`timescale 1ns/1ps
`default_nettype none

module lbt_layer_blend_properties
  import lbt_pkg::*;
(
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic [31:0] prdata_out,
  input wire logic pix_valid_in,
  input wire logic main_present_in,
  input wire logic [15:0] main_pix_in,
  input wire logic overlay_window_one_present_in,
  input wire logic [15:0] overlay_window_one_pix_in,
  input wire logic overlay_window_two_present_in,
  input wire logic [15:0] overlay_window_two_pix_in,
  input wire logic [15:0] pix_out
);
  // ========
  // Shadow registers; assume whole half-word writes
  logic [15:0] ctrl_q, bg_q, k1_q, k2_q;
  wire logic wr = psel_in && penable_in && pwrite_in;
  wire logic p0 = main_present_in;
  wire logic p1 = overlay_window_one_present_in;
  wire logic p2 = overlay_window_two_present_in;
  wire logic [15:0] c0 = main_pix_in;
  wire logic [15:0] c1 = overlay_window_one_pix_in;
  wire logic [15:0] c2 = overlay_window_two_pix_in;
  // Blend keys off, so only the layer rules shape the pixel
  wire logic v1 = pix_valid_in && p1 && !p2 && ctrl_q[11:8] == 4'h0;
  wire logic v2 = pix_valid_in && p2 && ctrl_q[11:8] == 4'h0;
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      ctrl_q <= CTRL_RST;
      bg_q <= BG_RST;
      k1_q <= KEY_RST;
      k2_q <= KEY_RST;
    end else if (wr) begin
      if (paddr_in == {IDX_CTRL, 2'b00}) ctrl_q <= pwdata_in[15:0] & CTRL_WMASK;
      if (paddr_in == {IDX_BG, 2'b00}) bg_q <= pwdata_in[15:0];
      if (paddr_in == {IDX_TKEY1, 2'b00}) k1_q <= pwdata_in[15:0];
      if (paddr_in == {IDX_TKEY2, 2'b00}) k2_q <= pwdata_in[15:0];
    end
  end
  // ========
  // Properties
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (reset_in);
  sequence s_setup; psel_in && !penable_in; endsequence
  sequence s_rd_ctrl; psel_in && penable_in && !pwrite_in && paddr_in == {IDX_CTRL, 2'b00};
  endsequence
  property p_rsv; s_setup ##1 s_rd_ctrl |-> prdata_out[15:0] == ctrl_q && !prdata_out[0];
  endproperty
  a_rsv: assert property (p_rsv) else $error("control readback wrong");
  property p_bg; pix_valid_in && !p0 && !p1 && !p2 |=> pix_out == $past(bg_q); endproperty
  a_bg: assert property (p_bg) else $error("background not shown");
  property p_ow1_off; v1 && !ctrl_q[1] |=> pix_out == $past(c1); endproperty
  a_ow1_off: assert property (p_ow1_off) else $error("window one not shown");
  property p_ow1_hit; v1 && ctrl_q[1] && c1 == k1_q && p0 |=> pix_out == $past(c0);
  endproperty
  a_ow1_hit: assert property (p_ow1_hit) else $error("main not revealed");
  property p_ow1_bare; v1 && ctrl_q[1] && !p0 |=> pix_out == $past(c1); endproperty
  a_ow1_bare: assert property (p_ow1_bare) else $error("window one key lost");
  property p_ow2_off; v2 && !ctrl_q[2] |=> pix_out == $past(c2); endproperty
  a_ow2_off: assert property (p_ow2_off) else $error("window two not shown");
  property p_ow2_hit; v2 && ctrl_q[2] && c2 == k2_q && p1 && !ctrl_q[1]
    |=> pix_out == $past(c1); endproperty
  a_ow2_hit: assert property (p_ow2_hit) else $error("window one not revealed");
  property p_ow2_bare; v2 && ctrl_q[2] && !p1 && !p0 |=> pix_out == $past(c2); endproperty
  a_ow2_bare: assert property (p_ow2_bare) else $error("window two key lost");
endmodule : lbt_layer_blend_properties

bind lbt_layer_blend lbt_layer_blend_properties lbt_layer_blend_properties_i (
  .clk_in, .reset_in, .psel_in, .penable_in, .pwrite_in, .paddr_in, .pwdata_in,
  .prdata_out, .pix_valid_in, .main_present_in, .main_pix_in,
  .overlay_window_one_present_in, .overlay_window_one_pix_in,
  .overlay_window_two_present_in, .overlay_window_two_pix_in, .pix_out);

`default_nettype wire

// File: testbench/lbt_layer_blend_tb_top.sv
// Testbench: register and compositing scenarios for the layer blend block
`timescale 1ns/1ps
`default_nettype none

module lbt_layer_blend_tb_top;
  import lbt_pkg::*;
  logic clk = 1'b0, rst = 1'b1, psel = 1'b0, pen = 1'b0, pw = 1'b0;
  logic pv = 1'b0, mp = 1'b0, p1 = 1'b0, p2 = 1'b0, err;
  logic [11:0] pa = '0;
  logic [31:0] pwd = '0;
  logic [15:0] mc = '0, c1 = '0, c2 = '0, rd;
  wire logic [31:0] prd;
  wire logic rdy, slv, vo;
  wire logic [15:0] po;
  int n_mismatch = 0;
  int num_checks = 0;
  lbt_layer_blend lbt_layer_blend_i (
    .clk_in(clk), .reset_in(rst), .psel_in(psel), .penable_in(pen), .pwrite_in(pw),
    .paddr_in(pa), .pwdata_in(pwd), .pstrb_in(4'h3), .prdata_out(prd),
    .pready_out(rdy), .pslverr_out(slv), .pix_valid_in(pv), .main_present_in(mp),
    .main_pix_in(mc), .overlay_window_one_present_in(p1), .overlay_window_one_pix_in(c1),
    .overlay_window_two_present_in(p2), .overlay_window_two_pix_in(c2),
    .pix_valid_out(vo), .pix_out(po));
  // ========
  // Shared tasks
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : report_and_stop
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    num_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("BAD %0t got %h want %h", $time, g, e);
    end
  endtask : chk
  // Request held until pready is seen high at a rising edge
  task automatic apb(input logic w, input logic [9:0] i, input logic [15:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pw <= w;
    pa <= {i, 2'b00};
    pwd <= {16'h0000, d};
    @(posedge clk);
    pen <= 1'b1;
    do begin
      @(posedge clk);
    end while (rdy !== 1'b1);
    rd = prd[15:0];
    err = slv;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask : apb
  task automatic px(input logic [2:0] pr, input logic [15:0] a, b, c, e);
    @(posedge clk);
    {p2, p1, mp} <= pr;
    mc <= a;
    c1 <= b;
    c2 <= c;
    pv <= 1'b1;
    @(posedge clk);
    pv <= 1'b0;
    #1;
    chk(po, e);
    chk({15'h0000, vo}, 16'h0001);
  endtask : px
  // ========
  // Scenarios
  task automatic t_regs;
    apb(1'b0, IDX_CTRL, 16'h0000);
    chk(rd, 16'h0000);
    apb(1'b0, IDX_BG, 16'h0000);
    chk(rd, 16'h0000);
    apb(1'b0, IDX_RATIO, 16'h0000);
    chk(rd, 16'h8888);
    apb(1'b1, IDX_CTRL, 16'hFFFF);
    apb(1'b0, IDX_CTRL, 16'h0000);
    chk(rd, 16'h0F86);
    apb(1'b1, IDX_CTRL, 16'h0000);
    apb(1'b1, IDX_TKEY1, 16'hF81F);
    apb(1'b0, IDX_TKEY1, 16'h0000);
    chk(rd, 16'hF81F);
    apb(1'b1, 10'h001, 16'h1234);
    chk({15'h0000, err}, 16'h0001);
    $display("test regs done");
  endtask : t_regs
  task automatic t_ow1;
    apb(1'b1, IDX_BG, 16'h07E0);
    px(3'b000, 16'h1111, 16'h2222, 16'h3333, 16'h07E0);
    apb(1'b1, IDX_CTRL, 16'h0002);
    px(3'b011, 16'h0AAA, 16'hF81F, 16'h0000, 16'h0AAA);
    px(3'b011, 16'h0AAA, 16'hF81E, 16'h0000, 16'hF81E);
    px(3'b010, 16'h0AAA, 16'hF81F, 16'h0000, 16'hF81F);
    apb(1'b1, IDX_CTRL, 16'h0000);
    px(3'b011, 16'h0AAA, 16'hF81F, 16'h0000, 16'hF81F);
    $display("test window one done");
  endtask : t_ow1
  task automatic t_ow2;
    apb(1'b1, IDX_TKEY2, 16'h001F);
    apb(1'b1, IDX_CTRL, 16'h0004);
    px(3'b110, 16'h0AAA, 16'h1111, 16'h001F, 16'h1111);
    px(3'b100, 16'h0AAA, 16'h1111, 16'h001F, 16'h001F);
    apb(1'b1, IDX_CTRL, 16'h0006);
    px(3'b111, 16'h0AAA, 16'hF81F, 16'h001F, 16'h0AAA);
    apb(1'b1, IDX_CTRL, 16'h0000);
    px(3'b110, 16'h0AAA, 16'h1111, 16'h001F, 16'h001F);
    $display("test window two done");
  endtask : t_ow2
  // White main over black background; codes 0, 3, 6 and 7 in turn, then 8
  task automatic t_blend;
    logic [3:0] r;
    logic [15:0] e;
    apb(1'b1, IDX_BG, 16'h0000);
    for (int k = 0; k < NUM_BKEY; k++) begin
      r = (k == 3) ? 4'h7 : 4'(3 * k);
      e = {5'((31 * r) >> 3), 6'((63 * r) >> 3), 5'((31 * r) >> 3)};
      apb(1'b1, IDX_BKEY1 + 10'(k), 16'hFFFF);
      apb(1'b1, IDX_RATIO, (16'h8888 & ~(16'h000F << (4 * k))) | (16'(r) << (4 * k)));
      apb(1'b1, IDX_CTRL, 16'h0100 << k);
      px(3'b001, 16'hFFFF, 16'h0000, 16'h0000, e);
      apb(1'b1, IDX_CTRL, 16'h0000);
      px(3'b001, 16'hFFFF, 16'h0000, 16'h0000, 16'hFFFF);
    end
    // Full weight shows the upper pixel unchanged
    apb(1'b1, IDX_RATIO, 16'h8888);
    apb(1'b1, IDX_CTRL, 16'h0800);
    px(3'b001, 16'hFFFF, 16'h0000, 16'h0000, 16'hFFFF);
    apb(1'b1, IDX_CTRL, 16'h0000);
    $display("test blend done");
  endtask : t_blend
  // ========
  // Clock, sequence and watchdog
  initial begin
    forever #25 clk = ~clk;
  end
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    t_regs;
    t_ow1;
    t_ow2;
    t_blend;
    report_and_stop;
  end
  initial begin
    #(50 * 4000);
    n_mismatch++;
    report_and_stop;
  end
endmodule : lbt_layer_blend_tb_top

`default_nettype wire
